// ==== verilog/dmbc_pkg.sv ====
`default_nettype none
package dmbc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timebase
  localparam int unsigned CLK_HZ      = 40_000_000;   // Control clock rate
  localparam int unsigned CLK_PER_US  = CLK_HZ / 1_000_000;
  localparam int unsigned OFF_TIME_NS = 25_000;       // Fixed off-time
  localparam int unsigned DEAD_NS     = 400;          // Crossover dead time
  localparam int unsigned STANDBY_US  = 1_000;        // Idle time before standby
  localparam int unsigned RETRY_US    = 2_000;        // Overcurrent retry timeout
  localparam int unsigned OFF_CYC     = (OFF_TIME_NS * CLK_PER_US) / 1000;
  localparam int unsigned DEAD_CYC    = (DEAD_NS * CLK_PER_US + 999) / 1000;
  localparam int unsigned STANDBY_CYC = STANDBY_US * CLK_PER_US;
  localparam int unsigned RETRY_CYC   = RETRY_US * CLK_PER_US;

  ////////////////////////////////////////////////////////////////////////////////
  // Register port
  localparam int unsigned ADDR_W = 4;                 // Byte address width
  localparam int unsigned DATA_W = 32;                // Data width
  localparam int unsigned TERM_W = 16;                // Width of terminal counts
  localparam logic [ADDR_W-1:0] REG_OFF_TERM  = 4'h0; // Off-time count, cycles
  localparam logic [ADDR_W-1:0] REG_DEAD_TERM = 4'h4; // Dead-time count, cycles
  localparam logic [ADDR_W-1:0] REG_STATUS    = 4'h8; // Block status, read only
  localparam logic [TERM_W-1:0] OFF_TERM_RST  = TERM_W'(OFF_CYC);
  localparam logic [TERM_W-1:0] DEAD_TERM_RST = TERM_W'(DEAD_CYC);

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {               // Decoded command {input a, input b}
    DMBC_COAST = 2'b00,
    DMBC_REV   = 2'b01,
    DMBC_FWD   = 2'b10,
    DMBC_BRAKE = 2'b11
  } dmbc_dir_t;

  typedef enum logic [1:0] {               // Current-chop phase
    DMBC_DRIVE = 2'b00,
    DMBC_FAST  = 2'b01,
    DMBC_DEAD  = 2'b10,
    DMBC_SLOW  = 2'b11
  } dmbc_phase_t;

  typedef struct packed {                  // Digital flags from the analog side
    logic current_trip;
    logic zero_current;
    logic over_temp;
    logic undervoltage_lockout;
    logic output_short;
  } dmbc_flags_t;

  typedef struct packed {                  // Gate enables of the full bridge
    logic a_hi;
    logic a_lo;
    logic b_hi;
    logic b_lo;
  } dmbc_gate_t;

  localparam dmbc_gate_t GATE_OFF = 4'h0;   // All off: outputs float
  localparam dmbc_gate_t GATE_FWD = 4'h9;   // A high, B low
  localparam dmbc_gate_t GATE_REV = 4'h6;   // A low, B high
  localparam dmbc_gate_t GATE_LOW = 4'h5;   // Both low: slow decay, brake

endpackage
`default_nettype wire

// ==== verilog/dmbc_bridge_ctrl.sv ====
// Notes on behaviour
// RULE1 - Decode inputs: reverse, forward, both high brakes
// RULE2 - Forward trip: A low, B chops
// RULE3 - Reverse trip: A chops, B low
// RULE4 - Both inputs low: outputs float, coast
// RULE5 - Inputs low over 1 ms: standby
// RULE6 - Standby shuts charge pump and regulator
// RULE7 - Host waits 200 us after wake
// RULE8 - Drive diagonal pair; trip starts off-time
// RULE9 - Fast decay half off-time, then slow
// RULE10 - Fast-to-slow change: all drivers off briefly
// RULE11 - Synchronous rectify, stop at zero current
// RULE12 - No rectification during dead time
// RULE13 - Output short pulls fault pin low
// RULE14 - Retry mode: re-enable after 2 ms
// RULE15 - Open retry select: latch, stay off
// RULE16 - Latched fault clears leaving standby
// RULE17 - Variant without retry always latches
// RULE18 - Over-temperature disables outputs until recovery
// RULE19 - Undervoltage keeps all outputs off
// RULE20 - Both high after chop: slow decay
// RULE21 - Analog flags arrive synchronised
// RULE22 - Timers share one timebase, set terminals
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module dmbc_bridge_ctrl
  import dmbc_pkg::*;
#(
  parameter bit          HAS_RETRY   = 1'b1,                 // Retry select pin present
  parameter int unsigned STANDBY_CYC = dmbc_pkg::STANDBY_CYC,
  parameter int unsigned RETRY_CYC   = dmbc_pkg::RETRY_CYC,
  parameter int unsigned LONG_W      = 17                    // Width of long timers
)(
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire logic                          drive_input_a,
  input  wire logic                          drive_input_b,
  input  wire logic                          retry_select,
  input  wire dmbc_pkg::dmbc_flags_t         flags,
  output logic                               bridge_output_a_hi,
  output logic                               bridge_output_a_lo,
  output logic                               bridge_output_b_hi,
  output logic                               bridge_output_b_lo,
  input  wire logic                          fault_out_n_i,
  output logic                               fault_out_n_o,
  output logic                               fault_out_n_oe_n,
  output logic                               standby,
  output logic                               charge_pump_en,
  output logic                               regulator_en,
  input  wire logic [dmbc_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [dmbc_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [dmbc_pkg::DATA_W-1:0]   reg_rdata
);
  import dmbc_pkg::*;

  localparam int unsigned SYNC_W = 9;                  // Pins and flags to synchronise

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [SYNC_W-1:0] sync1_r;                          // First synchroniser stage
  logic [SYNC_W-1:0] sync2_r;                          // Second synchroniser stage
  dmbc_flags_t       flg;                              // Synchronised flags
  dmbc_dir_t         dir;                              // Decoded command
  logic              retry_open;                       // Retry select left open
  logic              fault_pin;                        // Level seen on the fault pin
  dmbc_phase_t       phase_r;                          // Chop phase
  dmbc_phase_t       phase_nxt;
  logic [TERM_W-1:0] off_cnt_r;                        // Off-time cycle count
  logic [TERM_W-1:0] dead_cnt_r;                       // Dead-time cycle count
  logic              zc_seen_r;                        // Zero current seen this off-time
  logic [LONG_W-1:0] idle_cnt_r;                       // Both-inputs-low count
  logic              standby_r;                        // Low-power standby
  logic              wake;                             // Standby is being left
  logic              ocp_fault_r;                      // Overcurrent fault held
  logic              ocp_off_r;                        // Outputs disabled by overcurrent
  logic [LONG_W-1:0] retry_cnt_r;                      // Retry timeout count
  logic              latch_mode;                       // Overcurrent is latched
  logic              enabled;                          // Bridge may conduct
  logic              chopping;                         // Command is forward or reverse
  dmbc_gate_t        gate;                             // Next gate pattern
  dmbc_gate_t        gate_r;                           // Registered gate pattern
  logic [TERM_W-1:0] off_term_r;                       // Off-time terminal count
  logic [TERM_W-1:0] dead_term_r;                      // Dead-time terminal count
  logic [DATA_W-1:0] rdata_r;                          // Read data
  logic [DATA_W-1:0] status;                           // Status word

  // Address decode shared by the write and read paths
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for pins and analog flags
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= {fault_out_n_i, retry_select, drive_input_a, drive_input_b, flags};  // see RULE21
      sync2_r <= sync1_r;
    end
  end

  assign flg        = sync2_r[4:0];
  assign dir        = dmbc_dir_t'(sync2_r[6:5]);                 // see RULE1
  assign retry_open = sync2_r[SYNC_W-2];                         // Retry select level
  assign fault_pin  = sync2_r[SYNC_W-1];
  assign chopping   = (dir == DMBC_FWD) || (dir == DMBC_REV);
  assign latch_mode = !HAS_RETRY || retry_open;                  // see RULE15 see RULE17

  ////////////////////////////////////////////////////////////////////////////////
  // Standby timer: both inputs low for longer than the standby delay
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      idle_cnt_r <= '0;
      standby_r  <= 1'b0;
    end
    else if (dir != DMBC_COAST)
    begin
      // Any input high wakes the block
      idle_cnt_r <= '0;
      standby_r  <= 1'b0;
    end
    else if (idle_cnt_r == LONG_W'(STANDBY_CYC))
    begin
      standby_r <= 1'b1;                                         // see RULE5
    end
    else
    begin
      idle_cnt_r <= idle_cnt_r + LONG_W'(1);                     // see RULE22
    end
  end

  assign wake           = standby_r && (dir != DMBC_COAST);
  assign standby        = standby_r;
  assign charge_pump_en = !standby_r;                            // see RULE6
  assign regulator_en   = !standby_r;                            // see RULE6

  ////////////////////////////////////////////////////////////////////////////////
  // Overcurrent handling: retry timer or latched fault
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ocp_fault_r <= 1'b0;
      ocp_off_r   <= 1'b0;
      retry_cnt_r <= '0;
    end
    else if (flg.output_short && !ocp_off_r)
    begin
      // New short: disable and flag, detection wins over any clear
      ocp_fault_r <= 1'b1;                                       // see RULE13
      ocp_off_r   <= 1'b1;
      retry_cnt_r <= '0;
    end
    else if (wake)
    begin
      // Leaving standby clears a held fault
      ocp_fault_r <= 1'b0;                                       // see RULE16
      ocp_off_r   <= 1'b0;
      retry_cnt_r <= '0;
    end
    else if (ocp_off_r && !latch_mode)
    begin
      if (retry_cnt_r == LONG_W'(RETRY_CYC - 1))
      begin
        // Timeout: try the outputs again
        ocp_fault_r <= 1'b0;                                     // see RULE14
        ocp_off_r   <= 1'b0;
        retry_cnt_r <= '0;
      end
      else
      begin
        retry_cnt_r <= retry_cnt_r + LONG_W'(1);                 // see RULE22
      end
    end
  end

  assign fault_out_n_o    = 1'b0;                                // Open drain only pulls low
  assign fault_out_n_oe_n = !ocp_fault_r;                        // see RULE13

  // Outputs off in standby, undervoltage, over-temperature or overcurrent
  assign enabled = !standby_r && !flg.undervoltage_lockout       // see RULE19
                   && !flg.over_temp && !ocp_off_r;              // see RULE18

  ////////////////////////////////////////////////////////////////////////////////
  // Chop phase sequencing
  always_comb
  begin
    phase_nxt = phase_r;
    if (!chopping || !enabled)
    begin
      phase_nxt = DMBC_DRIVE;
    end
    else
    begin
      unique case (phase_r)
        DMBC_DRIVE:
        begin
          if (flg.current_trip)
          begin
            phase_nxt = DMBC_FAST;                               // see RULE8
          end
        end
        DMBC_FAST:
        begin
          if (off_cnt_r >= (off_term_r >> 1))
          begin
            phase_nxt = DMBC_DEAD;                               // see RULE9 see RULE10
          end
        end
        DMBC_DEAD:
        begin
          if (dead_cnt_r >= dead_term_r)
          begin
            phase_nxt = DMBC_SLOW;
          end
        end
        DMBC_SLOW:
        begin
          if (off_cnt_r >= off_term_r)
          begin
            phase_nxt = DMBC_DRIVE;                              // see RULE9
          end
        end
      endcase
    end
  end

  // Phase register and off-time counters
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      phase_r    <= DMBC_DRIVE;
      off_cnt_r  <= '0;
      dead_cnt_r <= '0;
    end
    else
    begin
      phase_r    <= phase_nxt;
      off_cnt_r  <= (phase_nxt == DMBC_DRIVE) ? '0 : off_cnt_r + TERM_W'(1);    // see RULE22
      dead_cnt_r <= (phase_nxt == DMBC_DEAD) ? dead_cnt_r + TERM_W'(1) : '0;
    end
  end

  // Zero-current memory for synchronous rectification
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      zc_seen_r <= 1'b0;
    end
    else if (phase_nxt == DMBC_DRIVE)
    begin
      zc_seen_r <= 1'b0;
    end
    else if (flg.zero_current)
    begin
      zc_seen_r <= 1'b1;                                         // see RULE11
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Gate pattern decode
  always_comb
  begin
    gate = GATE_OFF;
    if (!enabled)
    begin
      gate = GATE_OFF;
    end
    else
    begin
      unique case (dir)
        DMBC_COAST: gate = GATE_OFF;                             // see RULE4
        DMBC_BRAKE: gate = GATE_LOW;                             // see RULE20
        default:
        begin
          unique case (phase_r)
            DMBC_DRIVE: gate = (dir == DMBC_FWD) ? GATE_FWD : GATE_REV;     // see RULE1 see RULE8
            // Opposite pair conducts the decay current
            DMBC_FAST:  gate = zc_seen_r ? GATE_OFF
                               : ((dir == DMBC_FWD) ? GATE_REV : GATE_FWD); // see RULE2 see RULE3
            DMBC_DEAD:  gate = GATE_OFF;                                    // see RULE10 see RULE12
            DMBC_SLOW:  gate = zc_seen_r ? GATE_OFF : GATE_LOW;             // see RULE11
          endcase
        end
      endcase
    end
  end

  // Registered bridge drive
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      gate_r <= GATE_OFF;
    end
    else
    begin
      gate_r <= gate;
    end
  end

  assign bridge_output_a_hi = gate_r.a_hi;
  assign bridge_output_a_lo = gate_r.a_lo;
  assign bridge_output_b_hi = gate_r.b_hi;
  assign bridge_output_b_lo = gate_r.b_lo;

  ////////////////////////////////////////////////////////////////////////////////
  // Register port: writes
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      off_term_r  <= OFF_TERM_RST;
      dead_term_r <= DEAD_TERM_RST;
    end
    else if (reg_wr)
    begin
      if (hit(reg_addr, REG_OFF_TERM))
      begin
        off_term_r <= reg_wdata[TERM_W-1:0];                     // see RULE22
      end
      if (hit(reg_addr, REG_DEAD_TERM))
      begin
        dead_term_r <= reg_wdata[TERM_W-1:0];                    // see RULE22
      end
    end
  end

  // Status word: fault pin, fault, off, standby, phase, command
  assign status = {{(DATA_W-8){1'b0}}, fault_pin, ocp_fault_r, ocp_off_r, standby_r,
                   phase_r, dir};

  // Register port: reads, data valid only in the cycle after the strobe
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rdata_r <= '0;
    end
    else if (!reg_rd)
    begin
      rdata_r <= '0;
    end
    else if (hit(reg_addr, REG_OFF_TERM))
    begin
      rdata_r <= {{(DATA_W-TERM_W){1'b0}}, off_term_r};
    end
    else if (hit(reg_addr, REG_DEAD_TERM))
    begin
      rdata_r <= {{(DATA_W-TERM_W){1'b0}}, dead_term_r};
    end
    else if (hit(reg_addr, REG_STATUS))
    begin
      rdata_r <= status;
    end
    else
    begin
      rdata_r <= '0;                                             // Unmapped reads zero
    end
  end

  assign reg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_no_shoot;
    @(posedge mclk) disable iff (rst)
    !(gate_r.a_hi && gate_r.a_lo) && !(gate_r.b_hi && gate_r.b_lo);
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("Half bridge shoot-through");   // see RULE10

  property p_forward;
    @(posedge mclk) disable iff (rst)
    (enabled && dir == DMBC_FWD && phase_r == DMBC_DRIVE) |=> (gate_r == GATE_FWD);
  endproperty
  a_forward: assert property (p_forward) else $error("Forward drive pattern wrong");   // see RULE1

  property p_trip;
    @(posedge mclk) disable iff (rst)
    (enabled && chopping && phase_r == DMBC_DRIVE && flg.current_trip)
      |=> (phase_r == DMBC_FAST) ##1 (gate_r.a_lo == (dir == DMBC_FWD) || zc_seen_r || !enabled);
  endproperty
  a_trip: assert property (p_trip) else $error("Trip did not start fast decay");       // see RULE8

  property p_dead;
    @(posedge mclk) disable iff (rst)
    (phase_r == DMBC_DEAD && chopping) |=> (gate_r == GATE_OFF);
  endproperty
  a_dead: assert property (p_dead) else $error("Drivers on during dead time");         // see RULE12

  property p_fast_to_slow;
    @(posedge mclk) disable iff (rst)
    (phase_r == DMBC_FAST && phase_nxt != DMBC_FAST && enabled && chopping)
      |=> (phase_r == DMBC_DEAD);
  endproperty
  a_fast_to_slow: assert property (p_fast_to_slow) else $error("Slow decay without dead time"); // see RULE9

  property p_undervoltage_lockout;
    @(posedge mclk) disable iff (rst)
    flg.undervoltage_lockout |=> (gate_r == GATE_OFF);
  endproperty
  a_undervoltage_lockout: assert property (p_undervoltage_lockout) else $error("Outputs on in undervoltage");          // see RULE19

  property p_thermal;
    @(posedge mclk) disable iff (rst)
    flg.over_temp |=> (gate_r == GATE_OFF);
  endproperty
  a_thermal: assert property (p_thermal) else $error("Outputs on when over temperature"); // see RULE18

  property p_standby;
    @(posedge mclk) disable iff (rst)
    standby_r |-> (!charge_pump_en && !regulator_en) ##1 (gate_r == GATE_OFF);
  endproperty
  a_standby: assert property (p_standby) else $error("Standby left functions running"); // see RULE6

  property p_fault_pin;
    @(posedge mclk) disable iff (rst)
    (flg.output_short && !ocp_off_r) |=> (!fault_out_n_oe_n && ocp_off_r);
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("Short did not pull fault low"); // see RULE13

  property p_latched;
    @(posedge mclk) disable iff (rst)
    (ocp_fault_r && latch_mode && !wake) |=> ocp_fault_r;
  endproperty
  a_latched: assert property (p_latched) else $error("Latched fault cleared");         // see RULE15

  property p_retry_hold;
    @(posedge mclk) disable iff (rst)
    ($rose(ocp_off_r) && !latch_mode) |-> ocp_off_r [*8];
  endproperty
  a_retry_hold: assert property (p_retry_hold) else $error("Retry re-enabled too early"); // see RULE14

endmodule // dmbc_bridge_ctrl
`default_nettype wire

// ==== sim/dmbc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Host controller model: drives the two command pins
module dmbc_host_model #(
  parameter int unsigned SLEEP_CYC = 50,                         // Idle cycles before device sleeps
  parameter int unsigned WAKE_CYC  = 200 * dmbc_pkg::CLK_PER_US  // Charge pump settle wait
)(
  input  wire logic mclk,
  output var  logic drive_input_a,
  output var  logic drive_input_b
);
  import dmbc_pkg::*;
  int unsigned idle_cnt = 0;  // Cycles spent coasting
  initial
  begin
    drive_input_a = 1'b0;
    drive_input_b = 1'b0;
  end
  // Track coast time so the host knows when the device sleeps
  always @(posedge mclk)
    idle_cnt <= (drive_input_a | drive_input_b) ? 0 : idle_cnt + 1;
  // Apply a command; after a wake hold off further commands
  task automatic set_cmd(input dmbc_dir_t cmd);
    bit asleep;
    asleep = (idle_cnt > SLEEP_CYC + 4);
    @(posedge mclk);
    {drive_input_a, drive_input_b} <= cmd;
    if (asleep && cmd != DMBC_COAST)
      repeat (WAKE_CYC) @(posedge mclk);
  endtask
endmodule // dmbc_host_model
`default_nettype wire

// ==== sim/dmbc_bridge_ctrl_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench of the bridge control block
module dmbc_bridge_ctrl_bench;
  import dmbc_pkg::*;
  localparam int unsigned OFFT = 64;  // Off-time terminal used in the run
  localparam int unsigned DEADT = 8;  // Dead-time terminal used in the run
  logic mclk = 0, rst = 1, retry_sel = 0, a, b;
  dmbc_flags_t flg = '0;              // Analog-side flags
  logic [3:0] gates;                  // {a_hi,a_lo,b_hi,b_lo}
  logic oe_n, od, sb, cp_en, rg_en;
  logic [3:0] gates_l;                // Gates of the variant without retry select
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata, d;
  logic wr = 0, rd = 0;
  int error_cnt = 0, tests_run = 0;
  logic [31:0] xs_st = 32'h4;         // Random state
  dmbc_dir_t cmd, last;
  always #12.5 mclk = ~mclk;
  dmbc_host_model #(.SLEEP_CYC(50)) u_host (.mclk(mclk), .drive_input_a(a), .drive_input_b(b));
  dmbc_bridge_ctrl #(.STANDBY_CYC(50), .RETRY_CYC(100)) u_dut (
    .mclk(mclk), .rst(rst), .drive_input_a(a), .drive_input_b(b), .retry_select(retry_sel),
    .flags(flg), .bridge_output_a_hi(gates[3]), .bridge_output_a_lo(gates[2]),
    .bridge_output_b_hi(gates[1]), .bridge_output_b_lo(gates[0]), .fault_out_n_i(oe_n),
    .fault_out_n_o(od), .fault_out_n_oe_n(oe_n), .standby(sb), .charge_pump_en(cp_en),
    .regulator_en(rg_en), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata));
  // Variant without retry select: overcurrent always latches
  dmbc_bridge_ctrl #(.HAS_RETRY(1'b0), .STANDBY_CYC(50), .RETRY_CYC(100)) u_dut_latch (
    .mclk(mclk), .rst(rst), .drive_input_a(a), .drive_input_b(b), .retry_select(retry_sel),
    .flags(flg), .bridge_output_a_hi(gates_l[3]), .bridge_output_a_lo(gates_l[2]),
    .bridge_output_b_hi(gates_l[1]), .bridge_output_b_lo(gates_l[0]), .fault_out_n_i(oe_n),
    .fault_out_n_o(), .fault_out_n_oe_n(), .standby(), .charge_pump_en(),
    .regulator_en(), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata());
  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] xs();
    xs_st ^= xs_st << 13;
    xs_st ^= xs_st >> 17;
    xs_st ^= xs_st << 5;
    return xs_st;
  endfunction
  // Expected gate pattern of a command
  function automatic logic [3:0] exp_gate(input dmbc_dir_t c);
    case (c)
      DMBC_REV:   return GATE_REV;
      DMBC_FWD:   return GATE_FWD;
      DMBC_BRAKE: return GATE_LOW;
      default:    return GATE_OFF;
    endcase
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic reg_wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] v);
    @(posedge mclk);
    {wr, addr, wdata} <= {1'b1, ad, v};
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [ADDR_W-1:0] ad);
    @(posedge mclk);
    {rd, addr} <= {1'b1, ad};
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Forward or reverse chop cycle, optionally ending at zero current
  task automatic chop(input dmbc_dir_t c, input bit zc);
    u_host.set_cmd(c);
    cyc(6);
    @(posedge mclk) flg.current_trip <= 1'b1;
    cyc(2);
    flg.current_trip <= 1'b0;
    cyc(14);
    #1 chk(exp_gate(dmbc_dir_t'(~c)), gates);
    cyc(24);
    #1 chk(GATE_OFF, gates);
    cyc(6);
    flg.zero_current <= zc;
    cyc(6);
    #1 chk(zc ? GATE_OFF : GATE_LOW, gates);
    cyc(32);
    flg.zero_current <= 1'b0;
    #1 chk(exp_gate(c), gates);
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hang
  initial
  begin
    cyc(60000);
    error_cnt++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    cyc(10);
    rst <= 1'b0;
    #1 chk({GATE_OFF, 4'hb}, {gates, oe_n, od, cp_en, rg_en});
    reg_rd(REG_OFF_TERM);
    chk(32'(OFF_TERM_RST), d);
    reg_rd(REG_DEAD_TERM);
    chk(32'(DEAD_TERM_RST), d);
    reg_wr(4'hc, 32'hffffffff);
    reg_rd(4'hc);
    chk(32'h0, d);
    reg_wr(REG_OFF_TERM, OFFT);
    reg_wr(REG_DEAD_TERM, DEADT);
    reg_rd(REG_DEAD_TERM);
    chk(DEADT, d);
    $display("test registers done");
    last = DMBC_BRAKE;
    for (int i = 0; i < 16; i++)
    begin
      cmd = (i < 4) ? dmbc_dir_t'(i) : dmbc_dir_t'(xs() & 3);
      if (cmd == DMBC_COAST && last == DMBC_COAST)
        cmd = DMBC_BRAKE;
      last = cmd;
      u_host.set_cmd(cmd);
      cyc(4);
      #1 chk(exp_gate(cmd), gates);
    end
    reg_rd(REG_STATUS);
    chk(cmd, d[1:0]);
    $display("test decode done");
    chop(DMBC_FWD, 0);
    chop(DMBC_REV, 0);
    chop(DMBC_REV, 1);
    $display("test chop done");
    u_host.set_cmd(DMBC_COAST);
    cyc(40);
    #1 chk(3'h3, {sb, cp_en, rg_en});
    cyc(20);
    #1 chk(3'h4, {sb, cp_en, rg_en});
    u_host.set_cmd(DMBC_FWD);
    #1 chk(1'b0, sb);
    $display("test standby done");
    for (int k = 0; k < 2; k++)
    begin
      @(posedge mclk) {flg.over_temp, flg.undervoltage_lockout} <= k ? 2'b01 : 2'b10;
      cyc(6);
      #1 chk(GATE_OFF, gates);
      {flg.over_temp, flg.undervoltage_lockout} <= 2'b00;
      cyc(6);
      #1 chk(GATE_FWD, gates);
    end
    $display("test shutdown done");
    for (int m = 0; m < 2; m++)
    begin
      @(posedge mclk) retry_sel <= m[0];
      cyc(4);
      flg.output_short <= 1'b1;
      cyc(2);
      flg.output_short <= 1'b0;
      cyc(6);
      #1 chk({GATE_OFF, 1'b0}, {gates, oe_n});
      cyc(74);
      #1 chk({GATE_OFF, 1'b0}, {gates, oe_n});
      cyc(35);
      #1 chk(m ? {GATE_OFF, 1'b0} : {GATE_FWD, 1'b1}, {gates, oe_n});
      chk(GATE_OFF, gates_l);
    end
    reg_rd(REG_STATUS);
    chk(3'h3, d[7:5]);
    u_host.set_cmd(DMBC_COAST);
    cyc(60);
    u_host.set_cmd(DMBC_FWD);
    #1 chk({GATE_FWD, 1'b1}, {gates, oe_n});
    chk(GATE_FWD, gates_l);
    $display("test overcurrent done");
    report_and_stop();
  end
endmodule // dmbc_bridge_ctrl_bench
`default_nettype wire
